// ---- pkg/card_cmd_cfg.svh ----
// Constants for the SPI-mode card command decoder
`ifndef CARD_CMD_CFG_SVH
`define CARD_CMD_CFG_SVH
`define IDX_W            6
`define ARG_W            32
`define CMD_GO_IDLE      6'h00
`define CMD_OP_COND      6'h01
`define CMD_SWITCH       6'h06
`define CMD_IF_COND      6'h08
`define CMD_HIGH_IDX     6'h27
`define HCS_BIT          30
`define SW_MODE_BIT      31
`define FG2_HI           7
`define FG2_LO           4
`define FG1_HI           3
`define FG1_LO           0
`define VHS_HI           11
`define VHS_LO           8
`define PAT_HI           7
`define PAT_LO           0
`define VHS_SUPPORTED    4'h1
`define R1_IDLE_BIT      0
`define R1_ILLEGAL_BIT   2
`define SW_RSV_HI        30
`define SW_RSV_LO        24
`define GRP_RSV_FIRST    2
`define GRP_RSV_LAST     5
`define GRP_W            4
`define GRP_ALL_ONES     4'hF
`define IF_RSV_HI        31
`define IF_RSV_LO        12
`define SUPPORT_MASK     64'h0FB4_047F_7B07_3743
`define WRITE_ERASE_MASK 64'h0000_0043_0B00_0000
`endif

// ---- pkg/card_cmd_pkg.sv ----
// Types shared by both ends of the command link
package card_cmd_pkg;
   typedef logic [5:0]  cmd_index_type;
   typedef logic [31:0] cmd_arg_type;
   typedef logic [7:0]  r1_type;
   typedef logic [3:0]  nibble_type;
endpackage : card_cmd_pkg

// ---- pkg/card_cmd_if.sv ----
// Command and response link between host end and card end
`timescale 1ns/1ps
interface card_cmd_if;
   import card_cmd_pkg::*;
   logic          cmd_valid;
   cmd_index_type cmd_index;
   cmd_arg_type   cmd_arg;
   logic          rsp_valid;
   r1_type        rsp_r1;
   logic [7:0]    rsp_echo;
   modport host (output cmd_valid, output cmd_index, output cmd_arg,
                 input rsp_valid, input rsp_r1, input rsp_echo);
   modport card (input cmd_valid, input cmd_index, input cmd_arg,
                 output rsp_valid, output rsp_r1, output rsp_echo);
endinterface : card_cmd_if

// ---- design/card_cmd_host.sv ----
// Host end: builds clean command frames from user requests
`timescale 1ns/1ps
`include "card_cmd_cfg.svh"
module card_cmd_host (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   card_cmd_if.host                        link,
   input  wire logic                       req_i,
   input  wire card_cmd_pkg::cmd_index_type req_index_i,
   input  wire card_cmd_pkg::cmd_arg_type   req_arg_i,
   output logic                            busy_o,
   output logic                            done_o,
   output card_cmd_pkg::r1_type            r1_o,
   output logic [7:0]                      echo_o
);
   import card_cmd_pkg::*;

   typedef struct packed {
      logic          busy;
      logic          done;
      logic          valid;
      cmd_index_type index;
      cmd_arg_type   arg;
      r1_type        r1;
      logic [7:0]    echo;
   } host_state_type;

   host_state_type cur_ff;
   host_state_type nxt_cur;

   // Argument cleaning: reserved bits forced to their legal values
   function automatic cmd_arg_type clean_arg(input cmd_index_type idx,
                                            input cmd_arg_type a);
      cmd_arg_type r;
      r = a;
      unique case (idx)
         `CMD_GO_IDLE: r = '0;
         `CMD_OP_COND: begin
            r = '0;
            r[`HCS_BIT] = a[`HCS_BIT];
         end
         `CMD_SWITCH: begin
            r[`SW_RSV_HI:`SW_RSV_LO] = '0;
            for (int g = `GRP_RSV_FIRST; g <= `GRP_RSV_LAST; g++) begin
               if (a[g*`GRP_W +: `GRP_W] != `GRP_ALL_ONES) begin
                  r[g*`GRP_W +: `GRP_W] = '0;
               end
            end
         end
         `CMD_IF_COND: r[`IF_RSV_HI:`IF_RSV_LO] = '0;
         default: r = a;
      endcase
      return r;
   endfunction : clean_arg

   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.valid = 1'b0;
      nxt_cur.done = 1'b0;
      if (!cur_ff.busy && req_i) begin
         nxt_cur.busy = 1'b1;
         nxt_cur.valid = 1'b1;
         nxt_cur.index = req_index_i;
         nxt_cur.arg = clean_arg(req_index_i, req_arg_i);
      end else if (cur_ff.busy && link.rsp_valid) begin
         nxt_cur.busy = 1'b0;
         nxt_cur.done = 1'b1;
         nxt_cur.r1 = link.rsp_r1;
         nxt_cur.echo = link.rsp_echo;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) cur_ff <= '0;
      else cur_ff <= nxt_cur;
   end

   assign link.cmd_valid = cur_ff.valid;
   assign link.cmd_index = cur_ff.index;
   assign link.cmd_arg   = cur_ff.arg;
   assign busy_o = cur_ff.busy;
   assign done_o = cur_ff.done;
   assign r1_o   = cur_ff.r1;
   assign echo_o = cur_ff.echo;
endmodule : card_cmd_host

// ---- design/card_cmd_card.sv ----
// Card end: decodes SPI-mode commands and interprets arguments
`timescale 1ns/1ps
`include "card_cmd_cfg.svh"
// Summary of operation
// - Index field is plain binary command number
// - Stuff and reserved argument bits ignored
// - Host zeroes argument of index 0 only; other argumentless indices pass unchanged
// - Only SPI-supported indices accepted; 2,3,4,7 not
// - SPI-reserved indices get no function
// - Class field stays valid in SPI mode
// - Index 0 resets to idle, R1 answer
// - Index 1 captures capacity flag, starts init
// - Capacity flag counts only after interface check
// - Host zeroes bits 31, 29:0 of index 1
// - Index 6 bit 31 selects check or switch (selections latch in both modes; bit 31 only gates switch_pulse_o)
// - Host zeroes bits 30:24 of index 6
// - Reserved function nibbles all zero or F
// - Command-system selection from bits 7:4
// - Access-mode selection from bits 3:0
// - Writable cards implement write and erase
// - Lock command mandatory; forced erase optional
// - Interface check tests voltage, echoes pattern
module card_cmd_card #(
   parameter logic        WRITABLE         = 1'b1,
   parameter logic        FORCED_ERASE_OK  = 1'b0,
   parameter logic [11:0] CLASS_FIELD      = 12'h5B5
) (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   card_cmd_if.card                     link,
   input  wire logic                    init_done_i,
   output logic                         idle_o,
   output logic                         init_active_o,
   output logic                         capacity_flag_o,
   output logic                         voltage_ok_o,
   output logic                         switch_pulse_o,
   output card_cmd_pkg::nibble_type     cmd_system_fn_o,
   output card_cmd_pkg::nibble_type     access_mode_fn_o,
   output logic [11:0]                  class_field_o,
   output logic                         forced_erase_ok_o,
   output logic                         exec_pulse_o,
   output card_cmd_pkg::cmd_index_type  exec_index_o
);
   import card_cmd_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      // Initialization progress
      logic          idle;
      logic          init_active;
      logic          if_seen;
      logic          capacity;
      logic          volt_ok;
      // Latched function selections and one-cycle pulses
      logic          sw_pulse;
      nibble_type    fg2;
      nibble_type    fg1;
      logic          exec;
      cmd_index_type exec_idx;
      // Answer to the host
      logic          rsp_valid;
      r1_type        r1;
      logic [7:0]    echo;
      // Fixed card properties
      logic [11:0]   class_field;
      logic          forced_erase_ok;
   } card_state_type;

   localparam logic [63:0] SUPPORT_TABLE     = `SUPPORT_MASK;
   localparam logic [63:0] WRITE_ERASE_TABLE = `WRITE_ERASE_MASK;

   card_state_type cur_ff;
   card_state_type nxt_cur;
   logic [63:0]    support;
   logic           legal;
   logic           answer_idle;
   logic           init_ending;
   // Decoded argument fields
   logic           arg_capacity;
   logic           arg_switch_mode;
   nibble_type     arg_cmd_system;
   nibble_type     arg_access_mode;
   nibble_type     arg_voltage;
   logic [7:0]     arg_pattern;

   // ----------------------------------------
   // Argument fields
   // ----------------------------------------
   // Only the named fields are ever read; stuff and reserved bits have no path
   assign arg_capacity    = link.cmd_arg[`HCS_BIT];
   assign arg_switch_mode = link.cmd_arg[`SW_MODE_BIT];
   assign arg_cmd_system  = link.cmd_arg[`FG2_HI:`FG2_LO];
   assign arg_access_mode = link.cmd_arg[`FG1_HI:`FG1_LO];
   assign arg_voltage     = link.cmd_arg[`VHS_HI:`VHS_LO];
   assign arg_pattern     = link.cmd_arg[`PAT_HI:`PAT_LO];

   // ----------------------------------------
   // Command support table
   // ----------------------------------------
   // A read-only card drops its write and erase indices from the table
   for (genvar i = 0; i < $bits(support); i++) begin : g_support
      assign support[i] = SUPPORT_TABLE[i]
                        & (WRITABLE | ~WRITE_ERASE_TABLE[i]);
   end
   assign legal = support[link.cmd_index];

   // ----------------------------------------
   // Answer idle bit
   // ----------------------------------------
   // A reset command reports the idle state it leaves behind; every other
   // index reports the state found on arrival
   assign answer_idle = (link.cmd_index == `CMD_GO_IDLE) | cur_ff.idle;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   assign init_ending = cur_ff.init_active & init_done_i;

   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.rsp_valid = 1'b0;
      nxt_cur.sw_pulse = 1'b0;
      nxt_cur.exec = 1'b0;
      if (init_ending) begin
         nxt_cur.init_active = 1'b0;
         nxt_cur.idle = 1'b0;
      end
      if (link.cmd_valid) begin
         nxt_cur.rsp_valid = 1'b1;
         nxt_cur.r1 = '0;
         nxt_cur.echo = '0;
         if (!legal) begin
            // Refused: only the answer changes, so a retry is harmless
            nxt_cur.r1[`R1_ILLEGAL_BIT] = 1'b1;
         end else begin
            nxt_cur.exec = 1'b1;
            nxt_cur.exec_idx = link.cmd_index;
            unique case (link.cmd_index)
               `CMD_GO_IDLE: begin
                  // The interface check is forgotten, so the flag must be re-armed
                  nxt_cur.idle = 1'b1;
                  nxt_cur.init_active = 1'b0;
                  nxt_cur.if_seen = 1'b0;
                  nxt_cur.capacity = 1'b0;
               end
               `CMD_OP_COND: begin
                  nxt_cur.init_active = cur_ff.idle;
                  nxt_cur.capacity = cur_ff.if_seen & arg_capacity;
               end
               `CMD_SWITCH: begin
                  nxt_cur.fg2 = arg_cmd_system;
                  nxt_cur.fg1 = arg_access_mode;
                  nxt_cur.sw_pulse = arg_switch_mode;
               end
               `CMD_IF_COND: begin
                  nxt_cur.if_seen = 1'b1;
                  nxt_cur.volt_ok = (arg_voltage == `VHS_SUPPORTED);
                  // The pattern goes back unchanged so the host can trust the link
                  nxt_cur.echo = arg_pattern;
               end
               // Indices without decoded fields only raise the execution pulse
               default: nxt_cur.exec = 1'b1;
            endcase
         end
         nxt_cur.r1[`R1_IDLE_BIT] = answer_idle;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   // Reset leaves the card idle, as after an index-0 command
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur_ff <= '0;
         cur_ff.idle <= 1'b1;
         cur_ff.class_field <= CLASS_FIELD;
         cur_ff.forced_erase_ok <= FORCED_ERASE_OK;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // ----------------------------------------
   // Link answer
   // ----------------------------------------
   assign link.rsp_valid = cur_ff.rsp_valid;
   assign link.rsp_r1    = cur_ff.r1;
   assign link.rsp_echo  = cur_ff.echo;

   // ----------------------------------------
   // Card outputs
   // ----------------------------------------
   assign idle_o            = cur_ff.idle;
   assign init_active_o     = cur_ff.init_active;
   assign capacity_flag_o   = cur_ff.capacity;
   assign voltage_ok_o      = cur_ff.volt_ok;
   assign switch_pulse_o    = cur_ff.sw_pulse;
   assign cmd_system_fn_o   = cur_ff.fg2;
   assign access_mode_fn_o  = cur_ff.fg1;
   assign class_field_o     = cur_ff.class_field;
   assign forced_erase_ok_o = cur_ff.forced_erase_ok;
   assign exec_pulse_o      = cur_ff.exec;
   assign exec_index_o      = cur_ff.exec_idx;
endmodule : card_cmd_card

// ---- verification/card_cmd_monitor.sv ----
// Assertions on the command link between host end and card end
`timescale 1ns/1ps
module card_cmd_monitor (
   input wire logic                        clk_i,
   input wire logic                        rst_i,
   input wire logic                        cmd_valid,
   input wire card_cmd_pkg::cmd_index_type cmd_index,
   input wire card_cmd_pkg::cmd_arg_type   cmd_arg,
   input wire logic                        rsp_valid,
   input wire card_cmd_pkg::r1_type        rsp_r1,
   input wire logic [7:0]                  rsp_echo
);
   import card_cmd_pkg::*;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ----------------------------------------
   // Card end
   // ----------------------------------------
   property p_answer; rsp_valid == $past(cmd_valid); endproperty
   a_answer: assert property (p_answer) else $error("answer not one cycle after command");
   property p_unsup; cmd_valid && cmd_index inside {6'h02, 6'h03, 6'h04, 6'h07} |=> rsp_r1[2];
   endproperty
   a_unsup: assert property (p_unsup) else $error("unsupported index not flagged");
   property p_io; cmd_valid && cmd_index == 6'h05 |=> rsp_r1[2]; endproperty
   a_io: assert property (p_io) else $error("io index not flagged");
   property p_reset; cmd_valid && cmd_index == 6'h00 |=> rsp_r1 == 8'h01; endproperty
   a_reset: assert property (p_reset) else $error("reset answer wrong");
   property p_switch; cmd_valid && cmd_index == 6'h06 |=> !rsp_r1[2]; endproperty
   a_switch: assert property (p_switch) else $error("switch command refused");
   property p_echo; cmd_valid && cmd_index == 6'h08 |=> rsp_echo == $past(cmd_arg[7:0]);
   endproperty
   a_echo: assert property (p_echo) else $error("check pattern not echoed");
   property p_noecho; rsp_valid && rsp_echo != 8'h00 |-> $past(cmd_index) == 6'h08; endproperty
   a_noecho: assert property (p_noecho) else $error("echo on other index");
   // ----------------------------------------
   // Host end argument cleaning
   // ----------------------------------------
   property p_noarg; cmd_valid && cmd_index == 6'h00 |-> cmd_arg == 32'h0; endproperty
   a_noarg: assert property (p_noarg) else $error("stuff argument not zero");
   property p_op; cmd_valid && cmd_index == 6'h01 |-> (cmd_arg & 32'hBFFF_FFFF) == 32'h0;
   endproperty
   a_op: assert property (p_op) else $error("reserved operating bits set");
   property p_sw; cmd_valid && cmd_index == 6'h06 |-> cmd_arg[30:24] == 7'h00 &&
      cmd_arg[23:20] inside {4'h0, 4'hF} && cmd_arg[11:8] inside {4'h0, 4'hF}; endproperty
   a_sw: assert property (p_sw) else $error("switch reserved fields dirty");
   c_cond: cover property (cmd_valid && cmd_index == 6'h08);
   c_mode: cover property (cmd_valid && cmd_index == 6'h06 && cmd_arg[31]);
   c_ill: cover property (rsp_valid && rsp_r1[2]);
endmodule : card_cmd_monitor

// ---- verification/tb_top.sv ----
// Self-checking bench driving the host end against the card end
`timescale 1ns/1ps
module tb_top;
   import card_cmd_pkg::*;
   logic          clk_i = 1'b0;
   logic          rst_i = 1'b1;
   logic          req = 1'b0;
   logic          init_done = 1'b0;
   cmd_index_type ridx = '0;
   cmd_arg_type   rarg = '0;
   logic          busy, done, idle, init_act, cap, v_ok, sw_p, fe, ex_p;
   r1_type        r1;
   logic [7:0]    echo;
   nibble_type    fn_s, fn_a;
   logic [11:0]   cls;
   cmd_index_type ex_i;
   int            n_mismatch = 0;
   int            cmp_count = 0;
   int            n_ex = 0;
   int            n_sw = 0;
   cmd_index_type bad [7] = '{6'h02, 6'h03, 6'h04, 6'h07, 6'h05, 6'h0E, 6'h27};
   card_cmd_if u_card_cmd_if ();
   card_cmd_host u_card_cmd_host (.clk_i(clk_i), .rst_i(rst_i), .link(u_card_cmd_if.host),
      .req_i(req), .req_index_i(ridx), .req_arg_i(rarg), .busy_o(busy), .done_o(done),
      .r1_o(r1), .echo_o(echo));
   card_cmd_card u_card_cmd_card (.clk_i(clk_i), .rst_i(rst_i), .link(u_card_cmd_if.card),
      .init_done_i(init_done), .idle_o(idle), .init_active_o(init_act), .capacity_flag_o(cap),
      .voltage_ok_o(v_ok), .switch_pulse_o(sw_p), .cmd_system_fn_o(fn_s),
      .access_mode_fn_o(fn_a), .class_field_o(cls), .forced_erase_ok_o(fe),
      .exec_pulse_o(ex_p), .exec_index_o(ex_i));
   card_cmd_monitor u_card_cmd_monitor (.clk_i(clk_i), .rst_i(rst_i),
      .cmd_valid(u_card_cmd_if.cmd_valid), .cmd_index(u_card_cmd_if.cmd_index),
      .cmd_arg(u_card_cmd_if.cmd_arg), .rsp_valid(u_card_cmd_if.rsp_valid),
      .rsp_r1(u_card_cmd_if.rsp_r1), .rsp_echo(u_card_cmd_if.rsp_echo));
   initial forever #12.5 clk_i = ~clk_i;
   // Pulses are counted so that a refused command shows no hidden execution
   always @(posedge clk_i) begin
      if (ex_p === 1'b1) n_ex++;
      if (sw_p === 1'b1) n_sw++;
   end
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic send(input cmd_index_type i, input cmd_arg_type a);
      int k;
      @(negedge clk_i);
      ridx = i;
      rarg = a;
      req = 1'b1;
      @(negedge clk_i);
      req = 1'b0;
      chk(busy, 1'b1);
      for (k = 0; k < 20 && done !== 1'b1; k++) @(negedge clk_i);
      if (k == 20) begin
         n_mismatch++;
         print_verdict();
      end
   endtask : send
   initial begin
      int e;
      repeat (6) @(posedge clk_i);
      @(negedge clk_i);
      rst_i = 1'b0;
      chk(idle, 1'b1);
      chk(cls, 12'h5B5);
      chk(fe, 1'b0);
      $display("test reset done");
      send(6'h08, 32'hFFFF_F1A5);
      chk(echo, 8'hA5);
      chk(v_ok, 1'b1);
      send(6'h01, 32'hFFFF_FFFF);
      chk(cap, 1'b1);
      chk(init_act, 1'b1);
      @(negedge clk_i);
      init_done = 1'b1;
      @(negedge clk_i);
      init_done = 1'b0;
      chk({idle, init_act}, 2'b00);
      send(6'h00, 32'hFFFF_FFFF);
      chk({idle, cap, r1}, 10'h201);
      send(6'h01, 32'h4000_0000);
      chk(cap, 1'b0);
      send(6'h08, 32'h0000_02C3);
      chk({v_ok, echo}, 9'h0C3);
      $display("test init done");
      e = n_sw;
      send(6'h06, 32'h80FF_FF5A);
      chk({fn_s, fn_a, ex_i}, 14'h1686);
      chk(n_sw, e + 1);
      send(6'h06, 32'h0000_0036);
      chk({fn_s, fn_a}, 8'h36);
      chk(n_sw, e + 1);
      $display("test switch done");
      e = n_ex;
      foreach (bad[j]) begin
         send(bad[j], 32'h0);
         chk(r1[2], 1'b1);
      end
      chk(n_ex, e);
      chk({idle, fn_s, fn_a}, 9'h136);
      send(6'h18, 32'h0);
      chk(r1[2], 1'b0);
      chk(n_ex, e + 1);
      send(6'h2A, 32'h0);
      chk(r1[2], 1'b0);
      chk(n_ex, e + 2);
      $display("test refusal done");
      print_verdict();
   end
endmodule : tb_top
